// file: hdl/clk_cfg_cfg.svh
/*
 Holds offsets, field positions, reset values and timing counts of the
 run-mode clock configuration block. Assumes inclusion by bare name.
*/
`ifndef CLK_CFG_CFG_SVH
`define CLK_CFG_CFG_SVH
`define OFF_RUN_MODE_CLOCK_CONFIG 8'h60
`define OFF_PLL_TRANSLATION 8'h64
`define OFF_PLL_STATUS 8'h68
`define BIT_PLL_VERIFY_IRQ 0
`define BIT_PLL_LOCKED 1
`define RCC_RESET 32'h078E3AC0
`define RCC_WRITE_MASK 32'h07DE3FFF
`define POS_SYSDIV 23
`define POS_DIV_EN 20
`define POS_PWM_DIV 17
`define POS_PLL_POWER_DOWN 13
`define POS_OEN 12
`define POS_BYPASS 11
`define POS_VERIFY 10
`define POS_CRYSTAL_FREQUENCY_CODE 6
`define VERIFY_TIMEOUT_NS 2000
`define VERIFY_TIMEOUT_CYC ((`VERIFY_TIMEOUT_NS + 7) / 8)
`endif

// file: hdl/clk_cfg_pkg.sv
/*
 Holds the types of the clock configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package clk_cfg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef struct packed {
        logic pwm_clk_en;
        logic pwm_clk_div;
        logic pll_power_down;
        logic pll_output_enable_n;
        logic bypass;
        logic [3:0] sys_divisor;
    } clk_ctl_s;
    typedef enum logic [1:0] {VERIFY_IDLE, VERIFY_WATCH, VERIFY_FAIL} verify_e;
endpackage

// file: hdl/pwm_prediv.sv
/*
 Power-of-two predivider for the pwm timing reference.
 Assumes divisor code changes are rare; counter restarts on code change.
*/
`timescale 1ns/100ps
`default_nettype none
module pwm_prediv
    import clk_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] pwm_clock_divisor,
    output logic tick,
    output logic div_clk
);
    typedef struct packed {
        logic [5:0] cnt;
        logic [2:0] code;
        logic tick;
        logic dclk;
    } st_s;
    st_s st_reg, st_next;
    logic [5:0] last;
    // codes above four all saturate at divide by 64
    always_comb begin
        unique case (pwm_clock_divisor)
            3'h0: last = 6'h01;
            3'h1: last = 6'h03;
            3'h2: last = 6'h07;
            3'h3: last = 6'h0F;
            3'h4: last = 6'h1F;
            default: last = 6'h3F;
        endcase
    end
    always_comb begin
        st_next = st_reg;
        st_next.code = pwm_clock_divisor;
        if (st_reg.code != pwm_clock_divisor || st_reg.cnt == last)
            st_next.cnt = 6'h00;
        else
            st_next.cnt = st_reg.cnt + 6'h01;
        // high in the first half, rising on the system clock edge
        st_next.tick = (st_next.cnt == 6'h00);
        st_next.dclk = (st_next.cnt <= (last >> 1));
    end
    always_ff @(posedge mclk) begin
        if (!resetn)
            st_reg <= '{cnt: 6'h00, code: 3'h7, tick: 1'b0, dclk: 1'b0};
        else
            st_reg <= st_next;
    end
    assign tick = st_reg.tick;
    assign div_clk = st_reg.dclk;
endmodule // pwm_prediv
`default_nettype wire

// file: hdl/clk_cfg.sv
/*
 Run-mode clock configuration register with pll controls, bypass select,
 pll verification timer and crystal to pll translation.
 Assumes a pll that reports a heartbeat from its own clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "clk_cfg_cfg.svh"
module clk_cfg
    import clk_cfg_pkg::*;
#(
    parameter int VERIFY_CYC = `VERIFY_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire reg_req_s req,
    input wire logic pll_alive,
    output logic [31:0] rdata,
    output clk_ctl_s ctl,
    output logic pwm_clk_out,
    output logic pll_verify_irq
);
    initial begin
        if (VERIFY_CYC < 1 || VERIFY_CYC > 65535)
            $error("VERIFY_CYC out of range");
    end
    typedef struct packed {
        logic [31:0] run_mode_clock_config;
        logic [31:0] rdata;
        logic [3:0] crystal_frequency_code_seen;
        logic [15:0] translation;
        logic [2:0] alive_sync;
        logic alive_level;
        logic [15:0] timer;
        verify_e vstate;
        logic irq;
        clk_ctl_s ctl;
        logic pwm_out;
    } st_s;
    st_s st_reg, st_next;
    logic pwm_tick, pwm_div_clk;
    logic [3:0] crystal_frequency_code;
    logic [15:0] xlate;
    assign crystal_frequency_code = st_reg.run_mode_clock_config[`POS_CRYSTAL_FREQUENCY_CODE +: 4];
    pwm_prediv u_prediv (
        .mclk(mclk),
        .resetn(resetn),
        .pwm_clock_divisor(st_reg.run_mode_clock_config[`POS_PWM_DIV +: 3]),
        .tick(pwm_tick),
        .div_clk(pwm_div_clk)
    );
    // translation table: {f[13:0] low, r in upper bits}, values neutral
    always_comb begin
        xlate = {4'h0, 4'h0, crystal_frequency_code, 4'h0} + 16'h0100;
    end
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 32'h00000000;
        if (req.wr && req.addr == `OFF_RUN_MODE_CLOCK_CONFIG)
            st_next.run_mode_clock_config = (req.wdata & `RCC_WRITE_MASK);
        if (req.wr && req.addr == `OFF_PLL_STATUS &&
            req.wdata[`BIT_PLL_VERIFY_IRQ])
            st_next.irq = 1'b0;
        if (req.rd) begin
            unique case (req.addr)
                `OFF_RUN_MODE_CLOCK_CONFIG: st_next.rdata = st_reg.run_mode_clock_config;
                `OFF_PLL_TRANSLATION:
                    st_next.rdata = {16'h0000, st_reg.translation};
                `OFF_PLL_STATUS:
                    st_next.rdata = {30'h0, st_reg.alive_level, st_reg.irq};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        st_next.crystal_frequency_code_seen = crystal_frequency_code;
        if (st_reg.crystal_frequency_code_seen != crystal_frequency_code)
            st_next.translation = xlate;
        // three stages; change taken once the last two agree
        st_next.alive_sync = {st_reg.alive_sync[1:0], pll_alive};
        if (st_reg.alive_sync[2] == st_reg.alive_sync[1])
            st_next.alive_level = st_reg.alive_sync[2];
        // verification timer: heartbeat toggles must keep arriving
        unique case (st_reg.vstate)
            VERIFY_IDLE: begin
                st_next.timer = 16'h0000;
                if (st_reg.run_mode_clock_config[`POS_VERIFY] && !st_reg.run_mode_clock_config[`POS_PLL_POWER_DOWN])
                    st_next.vstate = VERIFY_WATCH;
            end
            VERIFY_WATCH: begin
                if (!st_reg.run_mode_clock_config[`POS_VERIFY] || st_reg.run_mode_clock_config[`POS_PLL_POWER_DOWN])
                    st_next.vstate = VERIFY_IDLE;
                else if (st_reg.alive_level != st_next.alive_level)
                    st_next.timer = 16'h0000;
                else if (st_reg.timer == 16'(VERIFY_CYC - 1))
                    st_next.vstate = VERIFY_FAIL;
                else
                    st_next.timer = st_reg.timer + 16'h0001;
            end
            VERIFY_FAIL: begin
                st_next.irq = 1'b1;
                st_next.vstate = VERIFY_IDLE;
            end
        endcase
        if (!st_reg.run_mode_clock_config[`POS_VERIFY] && st_reg.vstate != VERIFY_FAIL)
            st_next.vstate = VERIFY_IDLE;
        st_next.ctl.pll_power_down = st_reg.run_mode_clock_config[`POS_PLL_POWER_DOWN];
        st_next.ctl.pll_output_enable_n = st_reg.run_mode_clock_config[`POS_OEN];
        st_next.ctl.bypass = st_reg.run_mode_clock_config[`POS_BYPASS];
        st_next.ctl.sys_divisor = st_reg.run_mode_clock_config[`POS_SYSDIV +: 4];
        st_next.ctl.pwm_clk_en = st_reg.run_mode_clock_config[`POS_DIV_EN];
        st_next.ctl.pwm_clk_div = pwm_tick;
        // without the enable the pwm clock output is held low
        st_next.pwm_out = st_reg.run_mode_clock_config[`POS_DIV_EN] ? pwm_div_clk : 1'b0;
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.run_mode_clock_config <= `RCC_RESET;
            st_reg.crystal_frequency_code_seen <= 4'hB;
            st_reg.vstate <= VERIFY_IDLE;
            st_reg.ctl.pll_power_down <= 1'b1;
            st_reg.ctl.pll_output_enable_n <= 1'b1;
            st_reg.ctl.bypass <= 1'b1;
            st_reg.ctl.sys_divisor <= 4'hF;
        end else begin
            st_reg <= st_next;
        end
    end
    assign rdata = st_reg.rdata;
    assign ctl = st_reg.ctl;
    assign pwm_clk_out = st_reg.pwm_out;
    assign pll_verify_irq = st_reg.irq;
endmodule // clk_cfg
`default_nettype wire

// file: sim/clk_cfg_assertions.sv
/*
 Port checker for the clock configuration block.
 Assumes one clock and a bind onto every clk_cfg instance.
*/
`timescale 1ns/100ps
`default_nettype none
module clk_cfg_checker
    import clk_cfg_pkg::*;
#(
    parameter int VERIFY_CYC = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire reg_req_s req,
    input wire logic pll_alive,
    input wire logic [31:0] rdata,
    input wire clk_ctl_s ctl,
    input wire logic pwm_clk_out,
    input wire logic pll_verify_irq
);
    int quiet_reg;
    logic alive_reg;
    // raw heartbeat age; leads the synced copy, so a lower bound only
    always_ff @(posedge mclk) begin
        alive_reg <= pll_alive;
        quiet_reg <= (!resetn || pll_alive != alive_reg) ? 0 : quiet_reg + 1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_wr;
        req.wr && req.addr == 8'h60;
    endsequence
    property p_ro;
        req.rd && req.addr == 8'h60 |=> rdata[16:14] == 3'h0;
    endproperty
    property p_pd;
        s_wr |-> ##2 ctl.pll_power_down == $past(req.wdata[13], 2);
    endproperty
    property p_oen;
        s_wr |-> ##2 ctl.pll_output_enable_n == $past(req.wdata[12], 2);
    endproperty
    property p_byp;
        s_wr |-> ##2 ctl.bypass == $past(req.wdata[11], 2);
    endproperty
    property p_sys;
        s_wr |-> ##2 ctl.sys_divisor == $past(req.wdata[26:23], 2);
    endproperty
    property p_off;
        !ctl.pwm_clk_en && !$past(ctl.pwm_clk_en) |-> !pwm_clk_out;
    endproperty
    property p_irq;
        $rose(pll_verify_irq) |-> quiet_reg >= VERIFY_CYC;
    endproperty
    property p_map;
        req.rd && req.addr == 8'h70 |=> rdata == 32'h0;
    endproperty
    a_ro: assert property (p_ro) else $error("reserved bits set");
    a_pd: assert property (p_pd) else $error("power down wrong");
    a_oen: assert property (p_oen) else $error("output gate wrong");
    a_byp: assert property (p_byp) else $error("bypass wrong");
    a_sys: assert property (p_sys) else $error("divisor wrong");
    a_off: assert property (p_off) else $error("pwm clock leaks");
    a_irq: assert property (p_irq) else $error("early verify irq");
    a_map: assert property (p_map) else $error("unmapped read nonzero");
endmodule // clk_cfg_checker
bind clk_cfg clk_cfg_checker #(.VERIFY_CYC(VERIFY_CYC)) u_chk (
    .mclk(mclk), .resetn(resetn), .req(req), .pll_alive(pll_alive),
    .rdata(rdata), .ctl(ctl), .pwm_clk_out(pwm_clk_out),
    .pll_verify_irq(pll_verify_irq));
`default_nettype wire

// file: sim/pll_and_clock_source_config_bench.sv
/*
 Self-checking bench for clk_cfg against a register model.
 Assumes the port checker is bound; heartbeat is made here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "clk_cfg_cfg.svh"
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module pll_and_clock_source_config_bench
    import clk_cfg_pkg::*;
;
    logic mclk = 0, resetn = 0, pll_alive = 0, alive_run = 0;
    logic [1:0] hb = 2'h0;
    reg_req_s req = '0;
    logic [31:0] rdata, rcc_m = `RCC_RESET, tr_m = 0, seed = 72, exp_v;
    clk_ctl_s ctl;
    logic pwm_clk_out, pll_verify_irq;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    time t0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        // slow heartbeat: the synchroniser needs two equal samples
        if (alive_run) begin
            hb <= hb + 2'h1;
            if (hb == 2'h3)
                pll_alive <= ~pll_alive;
        end
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_mismatch++;
            test_done;
        end
    end
    clk_cfg #(.VERIFY_CYC(8)) dut (.mclk(mclk), .resetn(resetn),
        .req(req), .pll_alive(pll_alive), .rdata(rdata), .ctl(ctl),
        .pwm_clk_out(pwm_clk_out), .pll_verify_irq(pll_verify_irq));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
        if (a == 8'h60) begin
            exp_v = (rcc_m & ~`RCC_WRITE_MASK) | (d & `RCC_WRITE_MASK);
            if (exp_v[9:6] != rcc_m[9:6])
                tr_m = 32'h100 + {24'h0, exp_v[9:6], 4'h0};
            rcc_m = exp_v;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        @(negedge mclk);
        `CHK("rdata", e, rdata)
    endtask
    task automatic ctl_chk;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `CHK("pd", rcc_m[13], ctl.pll_power_down)
        `CHK("oen", rcc_m[12], ctl.pll_output_enable_n)
        `CHK("bypass", rcc_m[11], ctl.bypass)
        `CHK("sysdiv", rcc_m[26:23], ctl.sys_divisor)
        `CHK("pwm en", rcc_m[20], ctl.pwm_clk_en)
    endtask
    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        rd(8'h60, `RCC_RESET);
        ctl_chk;
        // verify enable kept off so random traffic leaves irq alone
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            // crystal code kept at four or above
            wr(8'h60, (seed | 32'h0001C100) & ~32'h400);
            ctl_chk;
            rd(8'h60, rcc_m);
            rd(8'h64, tr_m);
        end
        wr(8'h70, 32'hFFFFFFFF);
        rd(8'h70, 32'h0);
        rd(8'h60, rcc_m);
        for (int c = 0; c < 8; c++) begin
            wr(8'h60, 32'h00100000 | (32'(c) << 17));
            repeat (150) @(posedge mclk);
            @(posedge pwm_clk_out);
            t0 = $time;
            @(posedge pwm_clk_out);
            exp_v = 32'h2 << (c > 5 ? 5 : c);
            `CHK("pwm period", exp_v, 32'(($time - t0) / 8))
        end
        wr(8'h60, 32'h0);
        repeat (70) @(posedge mclk);
        @(negedge mclk);
        `CHK("pwm off", 1'b0, pwm_clk_out)
        `CHK("irq off", 1'b0, pll_verify_irq)
        // pll powered and driving, bypass clear
        wr(8'h60, 32'h400);
        alive_run <= 1'b1;
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        `CHK("irq alive", 1'b0, pll_verify_irq)
        alive_run <= 1'b0;
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        `CHK("irq stall", 1'b1, pll_verify_irq)
        wr(8'h60, 32'h0);
        wr(8'h68, 32'h1);
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        `CHK("irq clear", 1'b0, pll_verify_irq)
        test_done;
    end
endmodule // pll_and_clock_source_config_bench
`default_nettype wire
